// *** core/external_interrupt_unit.sv ***
// External pin and pin-change interrupt unit with its register file.
//
// Overview of operation
// - Pin activity raises requests even when pins are driven as outputs.
// - Group 2 covers inputs 23:16, group 1 inputs 15:8, group 0 inputs 7:0.
// - A pin-change input counts only when its per-group mask bit is set.
// - Pin-change activity is caught only through the clocked synchroniser; wake follows the group flags it sets.
// - Low-level sense keeps requesting while the enabled pin stays low.
// - Low level on pins 3:0 reaches wake asynchronously; edges are caught through the clocked synchroniser.
// - A low level on pins 3:0 gone before start-up ends wakes the part but raises no interrupt.
// - A pin interrupt is enabled only with its mask bit and global enable set.
// - Pins 3:0 use two-bit sense fields: low, any edge, falling, rising.
// - Pins 7:4 are sampled by the clock before edge detection.
// - Pins 7:4 sense: low, any change, falling or rising between samples.
// - Flags set on edge requests, clear on vector entry or write of one.
// - A pin flag stays cleared while the pin uses low-level sense.
// - Sleep with pins 3:0 disabled gates their input buffers, which may set flags.
// - A pin-change group is enabled only with its group bit and global enable.
// - Group flags set on a change, clear on vector entry or write of one.
`include "ext_irq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_unit (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic [7:0]  ext_irq_pins_i,
    input  wire logic [23:0] pin_change_inputs_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic        sleep_i,
    input  wire logic        startup_done_i,
    input  wire logic [10:0] vector_ack_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    output logic      [7:0]  pin_irq_req_o,
    output logic      [2:0]  group_irq_req_o,
    output logic             wake_o,
    output logic             irq_o
);
    ext_irq_pkg::byte_t ext_irq_sense_low;
    ext_irq_pkg::byte_t ext_irq_sense_high;
    ext_irq_pkg::byte_t ext_irq_enable_mask;
    ext_irq_pkg::byte_t ext_irq_flags;
    logic [2:0]         pin_change_group_enable;
    logic [2:0]         pin_change_group_flag;
    ext_irq_pkg::byte_t pin_change_mask_g0;
    ext_irq_pkg::byte_t pin_change_mask_g1;
    ext_irq_pkg::byte_t pin_change_mask_g2;
    logic [7:0]         pin_meta;
    logic [7:0]         pin_sync;
    logic [7:0]         pin_prev;
    logic [23:0]        pc_meta;
    logic [23:0]        pc_sync;
    logic [23:0]        pc_prev;
    logic [7:0]         pin_gated;
    logic [7:0]         edge_hit;
    logic [7:0]         level_hit;
    logic [23:0]        pc_toggle;
    logic [2:0]         group_hit;
    logic               wr_flags;
    logic               wr_pc_flags;
    logic               level_seen;

    function automatic ext_irq_pkg::sense_code_t sense_of(input logic [15:0] s, input int n);
        sense_of = s[2*n +: 2];
    endfunction

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // Pins driven as outputs still loop back through the input path, so software can raise requests.
    // In sleep, pins 3:0 with disabled interrupts have their buffers gated and read low.
    always_comb begin
        pin_gated = ext_irq_pins_i;
        for (int i = 0; i < 4; i++) begin
            if (sleep_i && !ext_irq_enable_mask[i]) begin
                pin_gated[i] = 1'b0;
            end
        end
    end

    // Two flip-flops bring pins into the clock domain; the first stage feeds only the second.
    // Low-level wake on pins 3:0 is formed from raw pin levels so it works while the clock is halted.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= `EXT_IRQ_RESET_BYTE;
            pin_sync <= `EXT_IRQ_RESET_BYTE;
            pin_prev <= `EXT_IRQ_RESET_BYTE;
            pc_meta  <= 24'h00_0000;
            pc_sync  <= 24'h00_0000;
            pc_prev  <= 24'h00_0000;
        end else if (clk_en_i) begin
            pin_meta <= pin_gated;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            pc_meta  <= pin_change_inputs_i;
            pc_sync  <= pc_meta;
            pc_prev  <= pc_sync;
        end
    end

    always_comb begin
        edge_hit  = 8'h00;
        level_hit = 8'h00;
        for (int i = 0; i < 8; i++) begin
            case (sense_of({ext_irq_sense_high, ext_irq_sense_low}, i))
                `EXT_IRQ_SENSE_LOW_LEVEL: level_hit[i] = !pin_sync[i];
                `EXT_IRQ_SENSE_ANY_EDGE:  edge_hit[i]  = pin_sync[i] ^ pin_prev[i];
                `EXT_IRQ_SENSE_FALLING:   edge_hit[i]  = pin_prev[i] & !pin_sync[i];
                `EXT_IRQ_SENSE_RISING:    edge_hit[i]  = !pin_prev[i] & pin_sync[i];
                default:                  edge_hit[i]  = 1'b0;
            endcase
        end
    end

    assign pc_toggle = pc_sync ^ pc_prev;
    assign group_hit[0] = |(pc_toggle[7:0]   & pin_change_mask_g0);
    assign group_hit[1] = |(pc_toggle[15:8]  & pin_change_mask_g1);
    assign group_hit[2] = |(pc_toggle[23:16] & pin_change_mask_g2);

    assign wr_flags    = wr_i && reg_hit(addr_i, `EXT_IRQ_OFS_FLAGS);
    assign wr_pc_flags = wr_i && reg_hit(addr_i, `EXT_IRQ_OFS_PC_FLAGS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_irq_sense_low       <= `EXT_IRQ_RESET_BYTE;
            ext_irq_sense_high      <= `EXT_IRQ_RESET_BYTE;
            ext_irq_enable_mask     <= `EXT_IRQ_RESET_BYTE;
            pin_change_group_enable <= 3'h0;
            pin_change_mask_g0      <= `EXT_IRQ_RESET_BYTE;
            pin_change_mask_g1      <= `EXT_IRQ_RESET_BYTE;
            pin_change_mask_g2      <= `EXT_IRQ_RESET_BYTE;
        end else if (clk_en_i && wr_i) begin
            // Changing a sense field with the pin enabled may fire a spurious request.
            if (reg_hit(addr_i, `EXT_IRQ_OFS_SENSE_LOW))   ext_irq_sense_low   <= wdata_i;
            if (reg_hit(addr_i, `EXT_IRQ_OFS_SENSE_HIGH))  ext_irq_sense_high  <= wdata_i;
            if (reg_hit(addr_i, `EXT_IRQ_OFS_ENABLE_MASK)) ext_irq_enable_mask <= wdata_i;
            if (reg_hit(addr_i, `EXT_IRQ_OFS_PC_CTRL)) begin
                pin_change_group_enable <= wdata_i[2:0];
            end
            if (reg_hit(addr_i, `EXT_IRQ_OFS_PC_MASK0))    pin_change_mask_g0  <= wdata_i;
            if (reg_hit(addr_i, `EXT_IRQ_OFS_PC_MASK1))    pin_change_mask_g1  <= wdata_i;
            if (reg_hit(addr_i, `EXT_IRQ_OFS_PC_MASK2))    pin_change_mask_g2  <= wdata_i;
        end
    end

    // A new event beats a clear in the same cycle so no request is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_irq_flags <= `EXT_IRQ_RESET_BYTE;
        end else if (clk_en_i) begin
            for (int i = 0; i < 8; i++) begin
                if (sense_of({ext_irq_sense_high, ext_irq_sense_low}, i) == `EXT_IRQ_SENSE_LOW_LEVEL) begin
                    ext_irq_flags[i] <= 1'b0;
                end else if (edge_hit[i]) begin
                    ext_irq_flags[i] <= 1'b1;
                end else if (vector_ack_i[i] || (wr_flags && wdata_i[i])) begin
                    ext_irq_flags[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_change_group_flag <= 3'h0;
        end else if (clk_en_i) begin
            for (int g = 0; g < `EXT_IRQ_PC_GROUP_BITS; g++) begin
                if (group_hit[g]) begin
                    pin_change_group_flag[g] <= 1'b1;
                end else if (vector_ack_i[8+g] || (wr_pc_flags && wdata_i[g])) begin
                    pin_change_group_flag[g] <= 1'b0;
                end
            end
        end
    end

    // Level requests are withheld until start-up completes; a level gone by then raises nothing.
    // The source must hold the level until the instruction ends.
    assign level_seen = startup_done_i;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_irq_req_o[i] = global_irq_enable_i && ext_irq_enable_mask[i]
                               && (ext_irq_flags[i] || (level_hit[i] && level_seen));
        end
        for (int g = 0; g < 3; g++) begin
            group_irq_req_o[g] = global_irq_enable_i && pin_change_group_enable[g]
                                 && pin_change_group_flag[g];
        end
    end

    assign irq_o = |pin_irq_req_o || |group_irq_req_o;

    // Low-level wake uses the raw pins, since in sleep the clock that feeds the synchroniser is halted.
    always_comb begin
        wake_o = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (ext_irq_enable_mask[i] && !pin_gated[i]
                && sense_of({ext_irq_sense_high, ext_irq_sense_low}, i) == `EXT_IRQ_SENSE_LOW_LEVEL) begin
                wake_o = 1'b1;
            end
        end
        if (|ext_irq_flags[3:0] || |pin_change_group_flag) begin
            wake_o = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= `EXT_IRQ_RESET_BYTE;
        end else if (clk_en_i) begin
            rdata_o <= `EXT_IRQ_RESET_BYTE;
            if (rd_i) begin
                case (addr_i)
                    `EXT_IRQ_OFS_SENSE_LOW:   rdata_o <= ext_irq_sense_low;
                    `EXT_IRQ_OFS_SENSE_HIGH:  rdata_o <= ext_irq_sense_high;
                    `EXT_IRQ_OFS_ENABLE_MASK: rdata_o <= ext_irq_enable_mask;
                    `EXT_IRQ_OFS_FLAGS:       rdata_o <= ext_irq_flags;
                    `EXT_IRQ_OFS_PC_CTRL:     rdata_o <= {5'h00, pin_change_group_enable};
                    `EXT_IRQ_OFS_PC_FLAGS:    rdata_o <= {5'h00, pin_change_group_flag};
                    `EXT_IRQ_OFS_PC_MASK0:    rdata_o <= pin_change_mask_g0;
                    `EXT_IRQ_OFS_PC_MASK1:    rdata_o <= pin_change_mask_g1;
                    `EXT_IRQ_OFS_PC_MASK2:    rdata_o <= pin_change_mask_g2;
                    default:                  rdata_o <= `EXT_IRQ_RESET_BYTE;
                endcase
            end
        end
    end
endmodule // external_interrupt_unit
`default_nettype wire

// *** core/ext_irq_consts.svh ***
// Register offsets, address width, group count, reset values and sense codes of the external interrupt unit.
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_ADDR_W          8
`define EXT_IRQ_OFS_SENSE_LOW   8'h69
`define EXT_IRQ_OFS_SENSE_HIGH  8'h6A
`define EXT_IRQ_OFS_ENABLE_MASK 8'h3D
`define EXT_IRQ_OFS_FLAGS       8'h3C
`define EXT_IRQ_OFS_PC_CTRL     8'h68
`define EXT_IRQ_OFS_PC_FLAGS    8'h3B
`define EXT_IRQ_OFS_PC_MASK0    8'h6B
`define EXT_IRQ_OFS_PC_MASK1    8'h6C
`define EXT_IRQ_OFS_PC_MASK2    8'h6D
`define EXT_IRQ_RESET_BYTE      8'h00
`define EXT_IRQ_PC_GROUP_BITS   3
`define EXT_IRQ_SENSE_LOW_LEVEL 2'b00
`define EXT_IRQ_SENSE_ANY_EDGE  2'b01
`define EXT_IRQ_SENSE_FALLING   2'b10
`define EXT_IRQ_SENSE_RISING    2'b11
`endif

// *** core/ext_irq_pkg.sv ***
// Types shared by the external interrupt unit.
package ext_irq_pkg;
    typedef logic [1:0] sense_code_t;
    typedef logic [7:0] byte_t;
endpackage

// *** verification/ext_irq_properties.sv ***
// Port assertions for the external interrupt unit.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        clk_en_i,
    input wire logic [23:0] pin_change_inputs_i,
    input wire logic        global_irq_enable_i,
    input wire logic [10:0] vector_ack_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [7:0]  pin_irq_req_o,
    input wire logic [2:0]  group_irq_req_o,
    input wire logic        wake_o,
    input wire logic        irq_o
);
    logic [2:0] quiet;
    // Inputs cross a synchroniser, so a change may still set a flag some edges later.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            quiet <= 3'h0;
        else if ($changed(pin_change_inputs_i[7:0]))
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence ack_g0_s;
        vector_ack_i[8] && clk_en_i && !wr_i && quiet == 3'h7;
    endsequence
    sequence held_g0_s;
        group_irq_req_o[0] && !wr_i && !vector_ack_i[8] ##1 global_irq_enable_i;
    endsequence
    a_pin_gie_gate: assert property (pin_irq_req_o != 8'h00 |-> global_irq_enable_i)
        else $error("pin request without global enable");
    a_group_gie_gate: assert property (group_irq_req_o != 3'h0 |-> global_irq_enable_i)
        else $error("group request without global enable");
    a_irq_or_all: assert property (irq_o == (|{pin_irq_req_o, group_irq_req_o}))
        else $error("irq output differs from requests");
    a_rdata_idle: assert property ($past(clk_en_i) && !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_rdata_frozen: assert property (!clk_en_i |=> $stable(rdata_o))
        else $error("read data moved while frozen");
    a_wake_group: assert property (group_irq_req_o != 3'h0 |-> wake_o)
        else $error("group request without wake");
    a_group_ack_clr: assert property (ack_g0_s |=> !group_irq_req_o[0])
        else $error("group flag survived vector entry");
    a_group_sticky: assert property (held_g0_s |-> group_irq_req_o[0])
        else $error("group flag lost");
endmodule // ext_irq_checker
`default_nettype wire

// *** verification/irq_entry_model.sv ***
// Interrupt entry model that takes one pending vector at a time.
`timescale 1ns/100ps
`default_nettype none
module irq_entry_model (
    input  wire logic        clk_i,
    input  wire logic        ack_en_i,
    input  wire logic [7:0]  pin_req_i,
    input  wire logic [2:0]  group_req_i,
    output logic      [10:0] vector_ack_o
);
    logic [10:0] pend;
    logic [10:0] ack = 11'h000;
    logic        busy = 1'b0;
    assign pend = {group_req_i, pin_req_i};
    assign vector_ack_o = ack;
    // A gap cycle follows each entry so the cleared flag is seen before the next pick.
    always_ff @(posedge clk_i) begin
        busy <= ack_en_i && pend != 11'h000 && !busy;
        ack  <= (ack_en_i && !busy) ? (pend & (~pend + 11'h001)) : 11'h000;
    end
endmodule // irq_entry_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the external interrupt unit.
`include "ext_irq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, global_irq_enable_i = 1'b0, startup_done_i = 1'b1;
    logic sleep_i = 1'b0, ack_en = 1'b0, wr_i = 1'b0, rd_i = 1'b0, wake_o, irq_o;
    logic [7:0] ext_irq_pins_i = 8'hFF, addr_i = 8'h00, wdata_i = 8'h00, rdata_o, pin_irq_req_o;
    logic [23:0] pin_change_inputs_i = 24'h00_0000;
    logic [10:0] vector_ack_i;
    logic [2:0] group_irq_req_o;
    logic [7:0] ofs [10] = '{`EXT_IRQ_OFS_SENSE_LOW, `EXT_IRQ_OFS_SENSE_HIGH, `EXT_IRQ_OFS_ENABLE_MASK,
        `EXT_IRQ_OFS_FLAGS, `EXT_IRQ_OFS_PC_CTRL, `EXT_IRQ_OFS_PC_FLAGS, `EXT_IRQ_OFS_PC_MASK0,
        `EXT_IRQ_OFS_PC_MASK1, `EXT_IRQ_OFS_PC_MASK2, 8'h00};
    int fail_count = 0, checks = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    external_interrupt_unit dut (.clk_i, .rst_i, .clk_en_i, .ext_irq_pins_i, .pin_change_inputs_i,
        .global_irq_enable_i, .sleep_i, .startup_done_i, .vector_ack_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .pin_irq_req_o, .group_irq_req_o, .wake_o, .irq_o);
    irq_entry_model partner (.clk_i(clk_i), .ack_en_i(ack_en), .pin_req_i(pin_irq_req_o),
        .group_req_i(group_irq_req_o), .vector_ack_o(vector_ack_i));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Strobes drop for one cycle between accesses, so no signal is driven twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        tick(1);
    endtask
    // Read data stand only in the cycle after the strobe, so they are compared inside that cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, e);
        tick(1);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        tick(6);
        rst_i <= 1'b0;
        tick(1);
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        wr(`EXT_IRQ_OFS_SENSE_LOW, 8'hA5);
        clk_en_i <= 1'b0;
        wr(`EXT_IRQ_OFS_SENSE_LOW, 8'h00);
        clk_en_i <= 1'b1;
        rd(`EXT_IRQ_OFS_SENSE_LOW, 8'hA5);
        global_irq_enable_i <= 1'b1;
        for (int p = 1; p < 8; p += 4) begin
            for (int c = 0; c < 4; c++) begin
                automatic logic [7:0] b = 8'(1 << p);
                wr(`EXT_IRQ_OFS_ENABLE_MASK, 8'h00);
                wr(p < 4 ? `EXT_IRQ_OFS_SENSE_LOW : `EXT_IRQ_OFS_SENSE_HIGH, 8'(c << (2 * (p % 4))));
                wr(`EXT_IRQ_OFS_FLAGS, 8'hFF);
                wr(`EXT_IRQ_OFS_ENABLE_MASK, b);
                ext_irq_pins_i[p] <= 1'b0;
                tick(5);
                check(pin_irq_req_o, c != 3 ? b : 8'h00);
                rd(`EXT_IRQ_OFS_FLAGS, (c == 1 || c == 2) ? b : 8'h00);
                startup_done_i <= 1'b0;
                tick(2);
                check(pin_irq_req_o, (c == 1 || c == 2) ? b : 8'h00);
                global_irq_enable_i <= 1'b0;
                tick(1);
                check(8'(irq_o), 8'h00);
                global_irq_enable_i <= 1'b1;
                startup_done_i <= 1'b1;
                ext_irq_pins_i[p] <= 1'b1;
                tick(5);
                rd(`EXT_IRQ_OFS_FLAGS, c != 0 ? b : 8'h00);
                wr(`EXT_IRQ_OFS_FLAGS, b);
                rd(`EXT_IRQ_OFS_FLAGS, 8'h00);
            end
        end
        wr(`EXT_IRQ_OFS_SENSE_LOW, 8'h08);
        wr(`EXT_IRQ_OFS_FLAGS, 8'hFF);
        sleep_i <= 1'b1;
        tick(5);
        rd(`EXT_IRQ_OFS_FLAGS, 8'h02);
        sleep_i <= 1'b0;
        tick(5);
        wr(`EXT_IRQ_OFS_FLAGS, 8'hFF);
        rd(`EXT_IRQ_OFS_FLAGS, 8'h00);
        wr(`EXT_IRQ_OFS_PC_CTRL, 8'h07);
        for (int g = 0; g < 3; g++) begin
            wr(8'(`EXT_IRQ_OFS_PC_MASK0 + g), 8'(1 << g));
            pin_change_inputs_i[8 * g + 7] <= 1'b1;
            tick(5);
            rd(`EXT_IRQ_OFS_PC_FLAGS, 8'h00);
            pin_change_inputs_i[8 * g + g] <= 1'b1;
            tick(5);
            rd(`EXT_IRQ_OFS_PC_FLAGS, 8'(1 << g));
            check(8'({wake_o, group_irq_req_o}), 8'(8 | (1 << g)));
            ack_en <= 1'b1;
            tick(4);
            ack_en <= 1'b0;
            rd(`EXT_IRQ_OFS_PC_FLAGS, 8'h00);
        end
        finish_test();
    end
endmodule // testbench
bind external_interrupt_unit ext_irq_checker chk (.clk_i, .rst_i, .clk_en_i, .pin_change_inputs_i,
    .global_irq_enable_i, .vector_ack_i, .wr_i, .rd_i, .rdata_o, .pin_irq_req_o, .group_irq_req_o,
    .wake_o, .irq_o);
`default_nettype wire
